// >>> irq_status_pkg.sv
// constants for the interrupt status collector
package irq_status_pkg;
    localparam int          ADDR_W        = 14;
    localparam int          DATA_W        = 32;
    localparam int          TIMER_W       = 16;
    // the status register answers at two aliased offsets
    localparam logic [13:0] STS_OFFSET    = 14'h0058;
    localparam logic [13:0] STS_ALIAS     = 14'h3058;
    // bit positions
    localparam int          SOFT_BIT      = 31;
    localparam int          READY_BIT     = 30;
    localparam int          PHY2_BIT      = 27;
    localparam int          PHY1_BIT      = 26;
    localparam int          TIMER_BIT     = 19;
    localparam int          POWER_BIT     = 17;
    localparam int          CORE_BIT      = 0;
    // defined bits and the write-one-to-clear subset
    localparam logic [31:0] DEFINED_MASK  = 32'hcc0a_0001;
    localparam logic [31:0] W1C_MASK      = 32'hc00a_0000;
    localparam logic [31:0] STS_RESET     = 32'h0000_0000;
    // the timer wraps from zero to its top value
    localparam logic [15:0] TIMER_ZERO    = 16'h0000;
    localparam logic [15:0] TIMER_TOP     = 16'hffff;
    // read data appears this many cycles after the read strobe
    localparam int          READ_LATENCY  = 1;
endpackage

// >>> event_flag_cell.sv
// one sticky status flag with set-over-clear priority
`timescale 1ns/1ps
module event_flag_cell (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic set_evt,
    input  wire logic clear_req,
    input  wire logic clear_allow,
    output logic      flag
);
    logic next_flag;

    // a set in the same cycle as a clear wins so no event is lost
    assign next_flag = set_evt | (flag & ~(clear_req & clear_allow));

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

    set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        set_evt |=> flag)
        else $error("flag not set after event");
endmodule

// >>> interrupt_status_collector.sv
// interrupt status register with aliased host access and irq output
`timescale 1ns/1ps
module interrupt_status_collector
    import irq_status_pkg::*;
#(
    parameter int TIMER_BITS = TIMER_W
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic [ADDR_W-1:0]     host_addr,
    input  wire logic                  host_wr,
    input  wire logic                  host_rd,
    input  wire logic [DATA_W-1:0]     host_wdata,
    output logic      [DATA_W-1:0]     host_rdata,
    output logic                       host_hit,
    input  wire logic                  soft_trigger_arm,
    input  wire logic                  device_ready,
    input  wire logic                  first_phy_event,
    input  wire logic                  second_phy_event,
    input  wire logic [TIMER_BITS-1:0] timer_count_value,
    input  wire logic                  power_event_pulse,
    input  wire logic                  power_event_pending,
    input  wire logic                  fieldbus_core_event,
    input  wire logic [DATA_W-1:0]     irq_enable,
    input  wire logic                  irq_out_enable,
    input  wire logic                  deassert_hold,
    output logic                       master_irq,
    output logic                       irq_pin
);
    logic                  arm_prev;
    logic                  ready_prev;
    logic [TIMER_BITS-1:0] timer_prev;
    logic                  timer_seen;
    logic                  soft_flag;
    logic                  ready_flag;
    logic                  timer_flag;
    logic                  power_flag;
    logic [DATA_W-1:0]     status;
    logic                  next_master;
    logic                  next_pin;

    function automatic logic addr_hits(input logic [ADDR_W-1:0] a);
        return (a == STS_OFFSET) || (a == STS_ALIAS);
    endfunction

    wire                  sts_sel     = addr_hits(host_addr);
    wire                  sts_wr      = host_wr & sts_sel;
    wire                  sts_rd      = host_rd & sts_sel;
    // only defined w1c positions react to a write; others ignore it
    wire [DATA_W-1:0]     clear_bits  = sts_wr ? (host_wdata & W1C_MASK) : '0;
    wire                  soft_set    = soft_trigger_arm & ~arm_prev;
    wire                  ready_set   = device_ready & ~ready_prev;
    // wrap seen only after one valid sample so reset does not fake it
    wire                  timer_set   = timer_seen && (timer_prev == TIMER_BITS'(TIMER_ZERO))
                                        && (timer_count_value == TIMER_BITS'(TIMER_TOP));
    wire                  power_clear_ok = ~power_event_pending;
    wire [DATA_W-1:0]     active_bits = status & irq_enable;
    wire                  power_active = power_flag & irq_enable[POWER_BIT];
    wire                  other_active = |(active_bits & ~(DATA_W'(1) << POWER_BIT));

    event_flag_cell u_soft (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .set_evt     (soft_set),
        .clear_req   (clear_bits[SOFT_BIT]),
        .clear_allow (1'b1),
        .flag        (soft_flag)
    );

    event_flag_cell u_ready (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .set_evt     (ready_set),
        .clear_req   (clear_bits[READY_BIT]),
        .clear_allow (1'b1),
        .flag        (ready_flag)
    );

    event_flag_cell u_timer (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .set_evt     (timer_set),
        .clear_req   (clear_bits[TIMER_BIT]),
        .clear_allow (1'b1),
        .flag        (timer_flag)
    );

    // a clear of the power flag is refused while power_event_pending is high
    event_flag_cell u_power (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .set_evt     (power_event_pulse),
        .clear_req   (clear_bits[POWER_BIT]),
        .clear_allow (power_clear_ok),
        .flag        (power_flag)
    );

    always_comb begin
        status            = STS_RESET;
        status[SOFT_BIT]  = soft_flag;
        status[READY_BIT] = ready_flag;
        status[PHY2_BIT]  = second_phy_event;
        status[PHY1_BIT]  = first_phy_event;
        status[TIMER_BIT] = timer_flag;
        status[POWER_BIT] = power_flag;
        status[CORE_BIT]  = fieldbus_core_event;
    end

    assign next_master = |active_bits;
    // hold applies to all sources except the power event
    assign next_pin    = irq_out_enable & (power_active | (other_active & ~deassert_hold));

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            arm_prev   <= 1'b0;
            ready_prev <= 1'b0;
            timer_prev <= '0;
            timer_seen <= 1'b0;
        end else begin
            arm_prev   <= soft_trigger_arm;
            ready_prev <= device_ready;
            timer_prev <= timer_count_value;
            timer_seen <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            host_rdata <= '0;
            host_hit   <= 1'b0;
        end else begin
            host_rdata <= sts_rd ? (status & DEFINED_MASK) : '0;
            host_hit   <= sts_rd;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            master_irq <= 1'b0;
            irq_pin    <= 1'b0;
        end else begin
            master_irq <= next_master;
            irq_pin    <= next_pin;
        end
    end

    // checks

    sequence soft_arm_rise;
        !soft_trigger_arm ##1 soft_trigger_arm;
    endsequence

    sequence ready_rise;
        !device_ready ##1 device_ready;
    endsequence

    sequence sts_read_req;
        host_rd && sts_sel;
    endsequence

    sequence timer_wrap_seq;
        timer_count_value == TIMER_BITS'(TIMER_ZERO) ##1 timer_count_value == TIMER_BITS'(TIMER_TOP);
    endsequence

    alias_read_same_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        sts_read_req |=> host_hit && (host_rdata == ($past(status) & DEFINED_MASK)))
        else $error("status read mismatch at alias");

    reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (host_rdata & ~DEFINED_MASK) == '0)
        else $error("reserved bit read nonzero");

    unmapped_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (host_rd && !sts_sel) |=> !host_hit && host_rdata == '0)
        else $error("unmapped read returned data");

    soft_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        soft_arm_rise |=> soft_flag)
        else $error("soft flag not set on arm");

    ready_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ready_rise |=> ready_flag)
        else $error("ready flag not set");

    timer_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        timer_seen ##0 timer_wrap_seq |=> timer_flag)
        else $error("timer wrap flag not set");

    w1c_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sts_wr && host_wdata[TIMER_BIT] && !timer_set) |=> !timer_flag)
        else $error("timer flag not cleared by write");

    w0_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ready_flag && !(sts_wr && host_wdata[READY_BIT])) |=> ready_flag)
        else $error("ready flag lost without write one");

    power_guard_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (power_flag && power_event_pending) |=> power_flag)
        else $error("power flag cleared while control pending");

    power_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sts_wr && host_wdata[POWER_BIT] && !power_event_pending && !power_event_pulse) |=> !power_flag)
        else $error("power flag not cleared");

    phy_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        sts_read_req |=> host_rdata[PHY1_BIT] == $past(first_phy_event)
                         && host_rdata[PHY2_BIT] == $past(second_phy_event)
                         && host_rdata[CORE_BIT] == $past(fieldbus_core_event))
        else $error("level bit does not follow source");

    master_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> master_irq == |($past(status) & $past(irq_enable)))
        else $error("master irq wrong");

    pin_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !$past(irq_out_enable) |-> !irq_pin)
        else $error("irq pin active while output disabled");

    power_no_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (power_active && irq_out_enable && deassert_hold) |=> irq_pin)
        else $error("power interrupt held back");

    soft_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sts_wr && host_wdata[SOFT_BIT] && !soft_set) |=> !soft_flag)
        else $error("soft flag not cleared by write");

    ready_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sts_wr && host_wdata[READY_BIT] && !ready_set) |=> !ready_flag)
        else $error("ready flag not cleared by write");

    power_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        power_event_pulse |=> power_flag)
        else $error("power flag not set on event");

    soft_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (soft_flag && !(sts_wr && host_wdata[SOFT_BIT])) |=> soft_flag)
        else $error("soft flag lost without write one");

    timer_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (timer_flag && !(sts_wr && host_wdata[TIMER_BIT])) |=> timer_flag)
        else $error("timer flag lost without write one");

    set_over_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (timer_set && sts_wr && host_wdata[TIMER_BIT]) |=> timer_flag)
        else $error("clear beat a same-cycle timer wrap");

    soft_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(soft_flag) |-> $past(soft_trigger_arm))
        else $error("soft flag rose without arm");

    ready_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(ready_flag) |-> $past(device_ready))
        else $error("ready flag rose without ready");

    timer_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(timer_flag) |-> $past(timer_count_value) == TIMER_BITS'(TIMER_TOP))
        else $error("timer flag rose without wrap");

    power_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(power_flag) |-> $past(power_event_pulse))
        else $error("power flag rose without event");

    pin_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (deassert_hold && !power_active) |=> !irq_pin)
        else $error("irq pin active during hold");

    pin_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (irq_out_enable && !deassert_hold && other_active) |=> irq_pin)
        else $error("enabled source did not reach irq pin");

    pin_master_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        irq_pin |-> master_irq)
        else $error("irq pin without master irq");

    hit_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        host_hit |-> $past(host_rd) && $past(sts_sel))
        else $error("hit without status read");

    wr_no_hit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (host_wr && !host_rd) |=> !host_hit)
        else $error("write produced a read hit");

    flags_reset_a: assert property (@(posedge core_clk)
        !rst_n |=> !soft_flag && !ready_flag && !timer_flag && !power_flag)
        else $error("flag survived reset");

    outputs_reset_a: assert property (@(posedge core_clk)
        !rst_n |=> !host_hit && !master_irq && !irq_pin && host_rdata == '0)
        else $error("output active after reset");
endmodule

// >>> interrupt_status_collector_tb.sv
// self-checking bench for the interrupt status collector
`timescale 1ns/1ps
module interrupt_status_collector_tb import irq_status_pkg::*; ;
    logic              core_clk;
    logic              rst_n;
    logic [ADDR_W-1:0] host_addr;
    logic              host_wr;
    logic              host_rd;
    logic [DATA_W-1:0] host_wdata;
    logic [DATA_W-1:0] host_rdata;
    logic              host_hit;
    logic              soft_trigger_arm;
    logic              device_ready;
    logic              first_phy_event;
    logic              second_phy_event;
    logic [15:0]       timer_count_value;
    logic              power_event_pulse;
    logic              power_event_pending;
    logic              fieldbus_core_event;
    logic [DATA_W-1:0] irq_enable;
    logic              irq_out_enable;
    logic              deassert_hold;
    logic              master_irq;
    logic              irq_pin;
    int                n_mismatch;
    int                n_compared;

    interrupt_status_collector #(.TIMER_BITS(16)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .host_addr(host_addr), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_hit(host_hit),
        .soft_trigger_arm(soft_trigger_arm), .device_ready(device_ready),
        .first_phy_event(first_phy_event), .second_phy_event(second_phy_event),
        .timer_count_value(timer_count_value), .power_event_pulse(power_event_pulse),
        .power_event_pending(power_event_pending), .fieldbus_core_event(fieldbus_core_event),
        .irq_enable(irq_enable), .irq_out_enable(irq_out_enable), .deassert_hold(deassert_hold),
        .master_irq(master_irq), .irq_pin(irq_pin)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic complete_run();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // every drive after the time-zero setup lands one nanosecond after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // read strobe for one cycle; answer stands only in the following cycle
    task automatic rd(input logic [13:0] a, input logic [31:0] exp, input logic hit);
        host_addr = a;
        host_rd = 1'b1;
        tick(1);
        host_rd = 1'b0;
        chk(host_rdata, exp);
        chk({31'h0, host_hit}, {31'h0, hit});
        tick(1);
    endtask

    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        host_addr = a;
        host_wdata = d;
        host_wr = 1'b1;
        tick(1);
        host_wr = 1'b0;
        tick(1);
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        n_mismatch = 0;
        n_compared = 0;
        rst_n = 1'b0;
        host_addr = 14'h0000;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 32'h0000_0000;
        soft_trigger_arm = 1'b0;
        device_ready = 1'b1;
        first_phy_event = 1'b0;
        second_phy_event = 1'b0;
        timer_count_value = 16'h8000;
        power_event_pulse = 1'b0;
        power_event_pending = 1'b0;
        fieldbus_core_event = 1'b0;
        irq_enable = 32'h0000_0000;
        irq_out_enable = 1'b0;
        deassert_hold = 1'b0;
        tick(10);
        rst_n = 1'b1;
        tick(3);
        rd(STS_OFFSET, 32'h1 << READY_BIT, 1'b1);
        wr(STS_OFFSET, 32'h0000_0000);
        rd(STS_ALIAS, 32'h1 << READY_BIT, 1'b1);
        wr(STS_ALIAS, 32'h1 << READY_BIT);
        rd(STS_OFFSET, 32'h0000_0000, 1'b1);
        wr(STS_OFFSET, 32'hffff_ffff);
        rd(STS_OFFSET, 32'h0000_0000, 1'b1);
        rd(14'h005c, 32'h0000_0000, 1'b0);
        soft_trigger_arm = 1'b1;
        tick(1);
        rd(STS_ALIAS, 32'h1 << SOFT_BIT, 1'b1);
        rd(STS_OFFSET, 32'h1 << SOFT_BIT, 1'b1);
        wr(STS_ALIAS, 32'h1 << SOFT_BIT);
        rd(STS_OFFSET, 32'h0000_0000, 1'b1);
        first_phy_event = 1'b1;
        second_phy_event = 1'b1;
        fieldbus_core_event = 1'b1;
        tick(1);
        rd(STS_OFFSET, 32'h0c00_0001, 1'b1);
        wr(STS_OFFSET, 32'h0c00_0001);
        rd(STS_OFFSET, 32'h0c00_0001, 1'b1);
        first_phy_event = 1'b0;
        fieldbus_core_event = 1'b0;
        tick(1);
        rd(STS_OFFSET, 32'h1 << PHY2_BIT, 1'b1);
        second_phy_event = 1'b0;
        timer_count_value = TIMER_ZERO;
        tick(1);
        timer_count_value = TIMER_TOP;
        tick(1);
        rd(STS_OFFSET, 32'h1 << TIMER_BIT, 1'b1);
        wr(STS_OFFSET, 32'h1 << TIMER_BIT);
        rd(STS_OFFSET, 32'h0000_0000, 1'b1);
        // power event passes the de-assertion interval but not the output enable
        irq_enable = 32'h1 << POWER_BIT;
        irq_out_enable = 1'b1;
        deassert_hold = 1'b1;
        power_event_pending = 1'b1;
        power_event_pulse = 1'b1;
        tick(1);
        power_event_pulse = 1'b0;
        tick(1);
        chk({31'h0, master_irq}, 32'h1);
        chk({31'h0, irq_pin}, 32'h1);
        irq_out_enable = 1'b0;
        tick(2);
        chk({31'h0, irq_pin}, 32'h0);
        chk({31'h0, master_irq}, 32'h1);
        wr(STS_OFFSET, 32'h1 << POWER_BIT);
        rd(STS_OFFSET, 32'h1 << POWER_BIT, 1'b1);
        power_event_pending = 1'b0;
        wr(STS_OFFSET, 32'h1 << POWER_BIT);
        rd(STS_OFFSET, 32'h0000_0000, 1'b1);
        chk({31'h0, master_irq}, 32'h0);
        // a mid-run reset must raise the ready flag again; arm drops first so no soft edge follows
        soft_trigger_arm = 1'b0;
        rst_n = 1'b0;
        tick(10);
        rst_n = 1'b1;
        irq_enable = 32'h1 << READY_BIT;
        irq_out_enable = 1'b1;
        deassert_hold = 1'b0;
        tick(1);
        chk({31'h0, master_irq}, 32'h0);
        chk({31'h0, irq_pin}, 32'h0);
        tick(1);
        chk({31'h0, master_irq}, 32'h1);
        chk({31'h0, irq_pin}, 32'h1);
        // the hold silences every source but the power event
        deassert_hold = 1'b1;
        tick(1);
        chk({31'h0, irq_pin}, 32'h0);
        chk({31'h0, master_irq}, 32'h1);
        rd(STS_ALIAS, 32'h1 << READY_BIT, 1'b1);
        complete_run();
    end
endmodule
